// ---- sie_pkg.sv ----
// package of constants and carrier types for the supervisor interrupt-enable block
package sie_pkg;
	// ==========================================================
	// register offsets
	localparam logic [7:0] SIE_PKT_CFG_OFS = 8'h11;
	localparam logic [7:0] SIE_FAST_UV_OFS = 8'h13;
	localparam logic [7:0] SIE_SLOW_UV_OFS = 8'h14;
	localparam logic [7:0] SIE_FAST_OV_OFS = 8'h15;
	localparam logic [7:0] SIE_SLOW_OV_OFS = 8'h16;
	localparam logic [7:0] SIE_CTRL_OFS = 8'h1B;
	// ==========================================================
	// field positions and writable masks
	localparam int SIE_CHANNEL_TWO_BIT = 1;
	localparam int SIE_CHANNEL_THREE_BIT = 2;
	localparam int SIE_CHANNEL_FOUR_BIT = 3;
	localparam int SIE_PACKET_CHECK_ERROR_BIT = 0;
	localparam int SIE_THERMAL_TRIP_BIT = 2;
	localparam int SIE_RUNTIME_MAP_CHECK_BIT = 4;
	localparam int SIE_PACKET_CHECK_ON_BIT = 0;
	localparam int SIE_PACKET_CHECK_MANDATORY_BIT = 1;
	localparam logic [7:0] SIE_CHAN_MASK = 8'h0E;
	localparam logic [7:0] SIE_CTRL_MASK = 8'h15;
	localparam logic [7:0] SIE_PKT_CFG_MASK = 8'h03;
	// ==========================================================
	// reset values and map check polynomial
	localparam logic [7:0] SIE_ENABLE_RST = 8'h00;
	localparam logic [7:0] SIE_PKT_CFG_RST = 8'h00;
	localparam logic [7:0] SIE_CRC_POLY = 8'h07;
	localparam logic [7:0] SIE_CRC_INIT = 8'h00;
	// ==========================================================
	// carriers
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sie_req_s;
	typedef struct packed {
		logic [2:0] fast_path_undervolt;
		logic [2:0] slow_path_undervolt;
		logic [2:0] fast_path_overvolt;
		logic [2:0] slow_path_overvolt;
		logic thermal;
	} sie_flt_s;
	typedef struct packed {
		logic done;
		logic check_byte_present;
		logic check_byte_good;
	} sie_pkt_s;
endpackage

// ---- sie_irq_enables.sv ----
// interrupt-enable register set, map integrity check and interrupt output of the supervisor
`timescale 1ns/10ps
`default_nettype none
module sie_irq_enables
	import sie_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire sie_req_s req,
	input wire sie_flt_s flags,
	input wire sie_pkt_s pkt,
	input wire logic map_fault_clr,
	input wire logic pkt_fault_clr,
	output logic [7:0] rdata,
	output logic map_fault,
	output logic pkt_fault,
	output logic interrupt_out_n,
	output logic interrupt_out_n_oe
);
	// ==========================================================
	// registers
	logic [7:0] fast_uv_q;
	logic [7:0] slow_uv_q;
	logic [7:0] fast_ov_q;
	logic [7:0] slow_ov_q;
	logic [7:0] ctrl_q;
	logic [7:0] pkt_cfg_q;
	logic [7:0] rdata_q;
	logic [7:0] crc_ref_q;
	logic crc_reload_q;
	logic map_fault_q;
	logic pkt_fault_q;
	logic irq_oe_q;

	// ==========================================================
	// decode
	wire hit_fast_uv = req.addr == SIE_FAST_UV_OFS;
	wire hit_slow_uv = req.addr == SIE_SLOW_UV_OFS;
	wire hit_fast_ov = req.addr == SIE_FAST_OV_OFS;
	wire hit_slow_ov = req.addr == SIE_SLOW_OV_OFS;
	wire hit_ctrl = req.addr == SIE_CTRL_OFS;
	wire hit_pkt = req.addr == SIE_PKT_CFG_OFS;
	wire wr_any = req.wr && (hit_fast_uv || hit_slow_uv || hit_fast_ov ||
		hit_slow_ov || hit_ctrl || hit_pkt);
	// reserved bits are dropped on write, so they always read zero
	wire [7:0] wdata_chan = req.wdata & SIE_CHAN_MASK;
	wire [7:0] wdata_ctrl = req.wdata & SIE_CTRL_MASK;
	wire [7:0] wdata_pkt = req.wdata & SIE_PKT_CFG_MASK;
	// one write strobe per register; unmapped offsets strobe nothing
	wire wr_fast_uv = req.wr && hit_fast_uv;
	wire wr_slow_uv = req.wr && hit_slow_uv;
	wire wr_fast_ov = req.wr && hit_fast_ov;
	wire wr_slow_ov = req.wr && hit_slow_ov;
	wire wr_ctrl = req.wr && hit_ctrl;
	wire wr_pkt = req.wr && hit_pkt;

	// the read path answers mapped offsets only, all else reads zero
	logic [7:0] rd_mux;
	always_comb begin
		if (hit_fast_uv) begin
			rd_mux = fast_uv_q;
		end else if (hit_slow_uv) begin
			rd_mux = slow_uv_q;
		end else if (hit_fast_ov) begin
			rd_mux = fast_ov_q;
		end else if (hit_slow_ov) begin
			rd_mux = slow_ov_q;
		end else if (hit_ctrl) begin
			rd_mux = ctrl_q;
		end else if (hit_pkt) begin
			rd_mux = pkt_cfg_q;
		end else begin
			rd_mux = 8'h00;
		end
	end

	// ==========================================================
	// register writes
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			fast_uv_q <= SIE_ENABLE_RST;
			slow_uv_q <= SIE_ENABLE_RST;
			fast_ov_q <= SIE_ENABLE_RST;
			slow_ov_q <= SIE_ENABLE_RST;
			ctrl_q <= SIE_ENABLE_RST;
			pkt_cfg_q <= SIE_PKT_CFG_RST;
		end else begin
			if (wr_fast_uv) begin
				fast_uv_q <= wdata_chan;
			end
			if (wr_slow_uv) begin
				slow_uv_q <= wdata_chan;
			end
			if (wr_fast_ov) begin
				fast_ov_q <= wdata_chan;
			end
			if (wr_slow_ov) begin
				slow_ov_q <= wdata_chan;
			end
			if (wr_ctrl) begin
				ctrl_q <= wdata_ctrl;
			end
			if (wr_pkt) begin
				pkt_cfg_q <= wdata_pkt;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata_q <= 8'h00;
		end else if (req.rd) begin
			rdata_q <= rd_mux;
		end
	end

	// ==========================================================
	// register map integrity check
	function automatic logic [7:0] sie_crc8(input logic [47:0] data);
		logic [7:0] c;
		c = SIE_CRC_INIT;
		for (int i = 47; i >= 0; i--) begin
			if (c[7] ^ data[i]) begin
				c = {c[6:0], 1'b0} ^ SIE_CRC_POLY;
			end else begin
				c = {c[6:0], 1'b0};
			end
		end
		return c;
	endfunction

	wire [7:0] crc_live = sie_crc8({fast_uv_q, slow_uv_q, fast_ov_q, slow_ov_q,
		ctrl_q, pkt_cfg_q});
	wire check_on = ctrl_q[SIE_RUNTIME_MAP_CHECK_BIT];
	// compare skipped in the reload cycle, the reference is one cycle behind a write
	wire crc_bad = check_on && !crc_reload_q && (crc_live != crc_ref_q);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			crc_reload_q <= 1'b1;
			crc_ref_q <= 8'h00;
		end else begin
			crc_reload_q <= wr_any;
			if (crc_reload_q) crc_ref_q <= crc_live;
		end
	end

	// ==========================================================
	// packet check evaluation
	wire pkt_on = pkt_cfg_q[SIE_PACKET_CHECK_ON_BIT];
	wire pkt_must = pkt_cfg_q[SIE_PACKET_CHECK_MANDATORY_BIT];
	wire pkt_bad = pkt.done && pkt_on && ((pkt.check_byte_present && !pkt.check_byte_good) ||
		(pkt_must && !pkt.check_byte_present));

	// set wins over a clear in the same cycle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			map_fault_q <= 1'b0;
			pkt_fault_q <= 1'b0;
		end else begin
			map_fault_q <= crc_bad || (map_fault_q && !map_fault_clr);
			pkt_fault_q <= pkt_bad || (pkt_fault_q && !pkt_fault_clr);
		end
	end

	// ==========================================================
	// interrupt mapping
	// flags lined up with the enable bit positions, bit 0 stays reserved
	wire [3:0] fast_uv_flt = {flags.fast_path_undervolt, 1'b0};
	wire [3:0] slow_uv_flt = {flags.slow_path_undervolt, 1'b0};
	wire [3:0] fast_ov_flt = {flags.fast_path_overvolt, 1'b0};
	wire [3:0] slow_ov_flt = {flags.slow_path_overvolt, 1'b0};
	// a flag counts only where its own enable bit is set
	wire [3:0] fast_uv_hit = fast_uv_flt & fast_uv_q[3:0];
	wire [3:0] slow_uv_hit = slow_uv_flt & slow_uv_q[3:0];
	wire [3:0] fast_ov_hit = fast_ov_flt & fast_ov_q[3:0];
	wire [3:0] slow_ov_hit = slow_ov_flt & slow_ov_q[3:0];
	wire uv_irq = (|fast_uv_hit) || (|slow_uv_hit);
	wire ov_irq = (|fast_ov_hit) || (|slow_ov_hit);
	wire map_irq = map_fault_q && ctrl_q[SIE_RUNTIME_MAP_CHECK_BIT];
	wire thermal_irq = flags.thermal && ctrl_q[SIE_THERMAL_TRIP_BIT];
	wire pkt_irq = pkt_fault_q && ctrl_q[SIE_PACKET_CHECK_ERROR_BIT];
	wire ctl_irq = map_irq || thermal_irq || pkt_irq;

	// open drain: only ever pulls low, the enable carries the level
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			irq_oe_q <= 1'b0;
		end else begin
			irq_oe_q <= uv_irq || ov_irq || ctl_irq;
		end
	end

	logic irq_low_q;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			irq_low_q <= 1'b0;
		end else begin
			irq_low_q <= 1'b0;
		end
	end

	assign rdata = rdata_q;
	assign map_fault = map_fault_q;
	assign pkt_fault = pkt_fault_q;
	assign interrupt_out_n = irq_low_q;
	assign interrupt_out_n_oe = irq_oe_q;
endmodule
`default_nettype wire

// ---- sie_props.sv ----
// checker of the interrupt-enable block ports
`timescale 1ns/10ps
`default_nettype none
module sie_props
	import sie_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire sie_req_s req,
	input wire sie_flt_s flags,
	input wire sie_pkt_s pkt,
	input wire logic map_fault_clr,
	input wire logic pkt_fault_clr,
	input wire logic [7:0] rdata,
	input wire logic map_fault,
	input wire logic pkt_fault,
	input wire logic interrupt_out_n,
	input wire logic interrupt_out_n_oe
);
	// ====
	// properties
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	wire hit = req.addr inside {8'h11, [8'h13:8'h16], 8'h1B};
	wire quiet = flags == '0 && !map_fault && !pkt_fault && !pkt.done;
	property p_pin; interrupt_out_n == 1'b0; endproperty
	a_pin: assert property (p_pin) else $error("pin");
	property p_quiet; quiet |=> !interrupt_out_n_oe; endproperty
	a_quiet: assert property (p_quiet) else $error("quiet");
	property p_chan; req.rd && req.addr inside {[8'h13:8'h16]} |=> !(rdata & 8'hF1); endproperty
	a_chan: assert property (p_chan) else $error("chan");
	property p_ctl; req.rd && req.addr == 8'h1B |=> !(rdata & 8'hEA); endproperty
	a_ctl: assert property (p_ctl) else $error("ctl");
	property p_unmap; req.rd && !hit |=> rdata == 8'h00; endproperty
	a_unmap: assert property (p_unmap) else $error("unmap");
	property p_pset; $rose(pkt_fault) |-> $past(pkt.done); endproperty
	a_pset: assert property (p_pset) else $error("pset");
	property p_pkeep; pkt_fault && !pkt_fault_clr |=> pkt_fault; endproperty
	a_pkeep: assert property (p_pkeep) else $error("pkeep");
	property p_map; !map_fault; endproperty
	a_map: assert property (p_map) else $error("map");
	cover property (req.rd && hit);
	cover property ($rose(interrupt_out_n_oe));
	cover property ($rose(pkt_fault));
endmodule
bind sie_irq_enables sie_props u_props (.clk(clk), .rstn(rstn), .req(req), .flags(flags),
	.pkt(pkt), .map_fault_clr(map_fault_clr), .pkt_fault_clr(pkt_fault_clr), .rdata(rdata),
	.map_fault(map_fault), .pkt_fault(pkt_fault), .interrupt_out_n(interrupt_out_n),
	.interrupt_out_n_oe(interrupt_out_n_oe));
`default_nettype wire

// ---- sie_host.sv ----
// host model issuing register accesses
`timescale 1ns/10ps
`default_nettype none
module sie_host
	import sie_pkg::*;
(
	input wire logic clk,
	input wire logic [7:0] rdata,
	output var sie_req_s req
);
	initial req = '{1'b0, 1'b0, 8'h5A, 8'hA5};
	// released fields are inverted so stale values never look valid
	task automatic acc(input logic w, input logic [7:0] a, d, output logic [7:0] q);
		@(negedge clk);
		req = '{w, !w, a, d};
		@(negedge clk);
		q = rdata;
		req = '{1'b0, 1'b0, ~a, ~d};
	endtask
endmodule
`default_nettype wire

// ---- supervisor_interrupt_enables_tb.sv ----
// self-checking bench of the interrupt-enable block
`timescale 1ns/10ps
`default_nettype none
`define CHK(x, e) begin samples_checked++; if ((x) !== (e)) begin error_cnt++; \
$display("BAD %0t %h %h", $time, (x), (e)); end end
module supervisor_interrupt_enables_tb
	import sie_pkg::*;
;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	sie_req_s req;
	sie_flt_s flags = '0;
	sie_pkt_s pkt = '0;
	logic pclr = 1'b0;
	logic [7:0] rdata, q, a, d;
	logic mf, pf, irq_n, oe;
	int error_cnt = 0;
	int samples_checked = 0;
	logic [7:0] ofs [6] = '{8'h11, 8'h13, 8'h14, 8'h15, 8'h16, 8'h1B};
	logic [7:0] msk [6] = '{8'h03, 8'h0E, 8'h0E, 8'h0E, 8'h0E, 8'h15};
	initial begin
		forever #2 clk = ~clk;
	end
	sie_irq_enables dut (.clk(clk), .rstn(rstn), .req(req), .flags(flags), .pkt(pkt),
		.map_fault_clr(pclr), .pkt_fault_clr(pclr), .rdata(rdata), .map_fault(mf),
		.pkt_fault(pf), .interrupt_out_n(irq_n), .interrupt_out_n_oe(oe));
	sie_host host (.clk(clk), .rdata(rdata), .req(req));
	task automatic rd(input logic [7:0] x, e);
		host.acc(1'b0, x, 8'h00, q);
		`CHK(q, e)
	endtask
	task automatic irq(input logic e);
		repeat (2) @(negedge clk);
		`CHK(oe, e)
		`CHK(irq_n, 1'b0)
	endtask
	task automatic pk(input logic p, g, e, i);
		@(negedge clk);
		pkt = '{1'b1, p, g};
		@(negedge clk);
		pkt = '0;
		irq(i);
		`CHK(pf, e)
		pclr = 1'b1;
		@(negedge clk);
		pclr = 1'b0;
	endtask
	task automatic print_verdict;
		$display("errors %0d checks %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		#20000;
		error_cnt++;
		print_verdict;
	end
	initial begin
		repeat (6) @(negedge clk);
		rstn = 1'b1;
		for (int i = 0; i < 6; i++) rd(ofs[i], 8'h00);
		host.acc(1'b1, 8'h20, 8'hFF, q);
		rd(8'h20, 8'h00);
		for (int i = 0; i < 6; i++) begin
			host.acc(1'b1, ofs[i], 8'hFF, q);
			rd(ofs[i], msk[i]);
		end
		// one flag at a time, then its own enable bit cleared
		for (int j = 0; j < 13; j++) begin
			flags = sie_flt_s'(13'h0001 << j);
			irq(1'b1);
			a = (j == 0) ? 8'h1B : 8'(8'h16 - (j - 1) / 3);
			d = (j == 0) ? 8'h11 : 8'(8'hFF ^ (8'h02 << (j - 1) % 3));
			host.acc(1'b1, a, d, q);
			irq(1'b0);
			flags = '0;
			host.acc(1'b1, a, 8'hFF, q);
		end
		pk(1'b1, 1'b0, 1'b1, 1'b1);
		pk(1'b0, 1'b0, 1'b1, 1'b1);
		pk(1'b1, 1'b1, 1'b0, 1'b0);
		host.acc(1'b1, 8'h11, 8'h01, q);
		pk(1'b0, 1'b0, 1'b0, 1'b0);
		host.acc(1'b1, 8'h1B, 8'h10, q);
		pk(1'b1, 1'b0, 1'b1, 1'b0);
		host.acc(1'b1, 8'h11, 8'h00, q);
		pk(1'b1, 1'b0, 1'b0, 1'b0);
		`CHK(mf, 1'b0)
		print_verdict;
	end
endmodule
`default_nettype wire
